// ===== dv/adc_serial_readout_tb.sv
`default_nettype none
`define chk(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module adc_serial_readout_tb;
  import adc_readout_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] EXT_LIM = 16'h0004;
  logic        mclk;
  logic        rst_n;
  logic        sdo_last;
  logic        ext_osc;
  logic        conv_done;
  logic [30:0] result;
  logic        cs_n, sck_drv, sck_oe_h, sck_pin, sdo_pin;
  logic        sck_out, sck_oe, pull_en, sdo_out, sdo_oe;
  logic        conv_start, ext_mode;
  int          fails = 0;
  int          n_checks = 0;
  // clock and reset
  always #4 mclk = ~mclk;
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    sdo_last = 1'b0;
    ext_osc = 1'b0;
    conv_done = 1'b0;
    result = '0;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
  end
  // pins: undriven sck sits on a board pull-up, released sdo toggles
  assign sck_pin = sck_oe ? sck_out : (sck_oe_h ? sck_drv : 1'b1);
  assign sdo_pin = sdo_oe ? sdo_out : ~sdo_last;
  always @(posedge mclk) sdo_last <= sdo_pin;
  spi_host_model host (
    .mclk(mclk), .sck_pin(sck_pin), .sdo_pin(sdo_pin),
    .cs_n(cs_n), .sck_drv(sck_drv), .sck_oe_h(sck_oe_h));
  adc_serial_readout #(.EXT_TEST_LIM(EXT_LIM)) dut (
    .mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .sck_in(sck_pin),
    .sck_out(sck_out), .sck_oe(sck_oe), .sck_pullup_en(pull_en),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .ext_osc_active(ext_osc),
    .conv_done(conv_done), .conv_result(result),
    .conv_start(conv_start), .ext_mode(ext_mode));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  // converter model: one-cycle done pulse with its word
  task automatic finish_conv(input logic [30:0] r);
    @(negedge mclk);
    result = r;
    conv_done = 1'b1;
    @(negedge mclk);
    conv_done = 1'b0;
  endtask : finish_conv
  task automatic wait_start(input int lim, output logic s);
    s = 1'b0;
    for (int i = 0; i < lim; i++) begin
      @(negedge mclk);
      if (conv_start === 1'b1) s = 1'b1;
    end
  endtask : wait_start
  task automatic t_ext_read;
    logic [31:0] w;
    logic        s;
    `chk("ext_mode", 1'b1, ext_mode)
    `chk("pullup", 1'b0, pull_en)
    `chk("sdo_oe", 1'b0, sdo_oe)
    host.select(1'b0);
    cyc(5);
    `chk("sdo busy", 1'b1, sdo_pin)
    finish_conv(31'h2b3c_4d5e);
    cyc(4);
    `chk("sdo done", 1'b0, sdo_pin)
    host.ext_frame(32, w);
    wait_start(12, s);
    `chk("frame", {1'b0, 31'h2b3c_4d5e}, w)
    `chk("restart", 1'b1, s)
    `chk("sdo conv", 1'b1, sdo_pin)
    host.select(1'b1);
    cyc(5);
    `chk("sdo_oe", 1'b0, sdo_oe)
    $display("t_ext_read done");
  endtask : t_ext_read
  task automatic t_ext_abort;
    logic [31:0] w;
    logic        s;
    finish_conv(31'h6000_0000);
    host.ext_frame(3, w);
    wait_start(10, s);
    `chk("no wake", 1'b0, s)
    host.select(1'b0);
    cyc(5);
    `chk("asleep", 1'b0, sdo_pin)
    host.ext_frame(5, w);
    `chk("head", 5'h0c, w[4:0])
    host.select(1'b1);
    wait_start(8, s);
    `chk("abort", 1'b1, s)
    $display("t_ext_abort done");
  endtask : t_ext_abort
  task automatic t_int_read;
    logic [31:0] w;
    logic        s;
    int          n;
    host.set_sck(1'b1, 1'b1);
    host.set_sck(1'b1, 1'b0);
    cyc(5);
    `chk("pullup", 1'b1, pull_en)
    host.select(1'b0);
    cyc(5);
    `chk("ext_mode", 1'b0, ext_mode)
    `chk("sck low", 1'b0, sck_pin)
    `chk("sdo busy", 1'b1, sdo_pin)
    finish_conv(31'h1234_5678);
    cyc(300);
    host.select(1'b1);
    wait_start(100, s);
    `chk("asleep", 1'b0, s)
    ext_osc = 1'b1;
    host.select(1'b0);
    n = 0;
    // pin is still pulled high here: count until driven low, then high
    fork
      host.int_frame(w);
      begin
        while (sck_pin !== 1'b0) begin
          @(negedge mclk);
          n++;
        end
        while (sck_pin !== 1'b1) begin
          @(negedge mclk);
          n++;
        end
      end
    join
    `chk("delay", 1'b1, (n >= 5 && n <= 16))
    `chk("frame", {1'b0, 31'h1234_5678}, w)
    wait_start(100, s);
    `chk("restart", 1'b1, s)
    `chk("sck high", 1'b1, sck_pin)
    `chk("sdo conv", 1'b1, sdo_pin)
    $display("t_int_read done");
  endtask : t_int_read
  // leave while sck is high, or the pin would stay low
  task automatic t_int_abort;
    logic s;
    finish_conv(31'h0000_0001);
    cyc(40);
    host.select(1'b1);
    wait_start(10, s);
    `chk("abort", 1'b1, s)
    $display("t_int_abort done");
  endtask : t_int_abort
  // main sequence
  initial begin
    @(posedge rst_n);
    cyc(5);
    t_ext_read();
    t_ext_abort();
    t_int_read();
    t_int_abort();
    tally_and_finish();
  end
  // watchdog: tests take about 5100 cycles
  initial begin
    repeat (30000) @(posedge mclk);
    fails++;
    tally_and_finish();
  end
endmodule : adc_serial_readout_tb
`default_nettype wire

// ===== dv/spi_host_model.sv
`default_nettype none
// ==========================
// host: select and serial clock
// ==========================
module spi_host_model (
  input  wire logic mclk,
  input  wire logic sck_pin,
  input  wire logic sdo_pin,
  output logic      cs_n,
  output logic      sck_drv,
  output logic      sck_oe_h
);
  timeunit 1ns;
  timeprecision 1ps;
  // sck held low through reset to strap external mode
  initial begin
    cs_n = 1'b1;
    sck_drv = 1'b0;
    sck_oe_h = 1'b1;
  end
  task automatic set_sck(input logic v, input logic oe);
    @(negedge mclk);
    sck_drv = v;
    sck_oe_h = oe;
  endtask : set_sck
  // sck level is settled before select falls
  task automatic select(input logic v);
    @(negedge mclk);
    cs_n = v;
  endtask : select
  // six cycles a half period: sync needs four
  task automatic ext_frame(input int n, output logic [31:0] w);
    w = '0;
    for (int i = 0; i < n; i++) begin
      repeat (6) @(negedge mclk);
      w = {w[30:0], sdo_pin};
      sck_drv = 1'b1;
      repeat (6) @(negedge mclk);
      sck_drv = 1'b0;
    end
  endtask : ext_frame
  // bits taken on the device's own rising edges
  task automatic int_frame(output logic [31:0] w);
    w = '0;
    for (int i = 0; i < 32; i++) begin
      @(posedge sck_pin);
      @(negedge mclk);
      w = {w[30:0], sdo_pin};
    end
  endtask : int_frame
endmodule : spi_host_model
`default_nettype wire

// ===== rtl/adc_readout_pkg.sv
`default_nettype none
package adc_readout_pkg;
  // ==========================================================
  // clock and timing
  // ==========================================================
  localparam int MCLK_MHZ       = 125;
  localparam int TEST_DELAY_NS  = 23000;  // status_test_delay, internal osc
  localparam int TEST_CYC       = (TEST_DELAY_NS * MCLK_MHZ + 999) / 1000;
  localparam logic [15:0] TEST_LIM = 16'(TEST_CYC - 1);
  localparam int CONV_CLK_CYC   = 16;     // mclk cycles per conversion tick
  localparam int SCK_DIV        = 8;      // serial clock = conv clock / 8
  localparam logic [3:0] CONV_TICK_LIM = 4'(CONV_CLK_CYC - 1);
  localparam logic [1:0] HALF_LIM      = 2'(SCK_DIV / 2 - 1);
  localparam int FRAME_BITS     = 32;
  localparam logic [5:0] LAST_EDGE     = 6'(FRAME_BITS);
  localparam logic [1:0] POR_CAPTURE   = 2'h2;

  // ==========================================================
  // readout sequencer states
  // ==========================================================
  typedef enum logic [1:0] {
    ST_CONVERT,
    ST_SLEEP,
    ST_WAIT,
    ST_SHIFT
  } rd_state_t;
endpackage : adc_readout_pkg
`default_nettype wire

// ===== rtl/adc_serial_readout.sv
`default_nettype none
module adc_serial_readout
  import adc_readout_pkg::*;
#(
  parameter logic [15:0] EXT_TEST_LIM = 16'h0100  // delay under external osc
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        cs_n,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  output logic             sck_pullup_en,
  output logic             sdo_out,
  output logic             sdo_oe,
  input  wire logic        ext_osc_active,
  input  wire logic        conv_done,
  input  wire logic [30:0] conv_result,
  output logic             conv_start,
  output logic             ext_mode
);

  // ==========================================================
  // input synchronisers and edge detection
  // ==========================================================
  logic cs_s;
  logic sck_s;
  logic cs_d;
  logic sck_d;

  sync2 #(.RST_VAL(1'b1)) u_cs_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (cs_n),
    .q     (cs_s)
  );

  sync2 #(.RST_VAL(1'b1)) u_sck_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (sck_in),
    .q     (sck_s)
  );

  // edges are taken from the synchronised copies only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cs_d  <= 1'b1;
      sck_d <= 1'b1;
    end else begin
      cs_d  <= cs_s;
      sck_d <= sck_s;
    end
  end

  wire cs_fall  = cs_d & ~cs_s;
  wire cs_rise  = ~cs_d & cs_s;
  wire sck_rise = ~sck_d & sck_s;
  wire sck_fall = sck_d & ~sck_s;

  // ==========================================================
  // state, counters
  // ==========================================================
  rd_state_t   st;
  rd_state_t   next_st;
  logic [1:0]  por_cnt;
  logic [3:0]  tick_cnt;
  logic [1:0]  half_cnt;
  logic [15:0] wait_cnt;
  logic [5:0]  bit_cnt;
  logic [31:0] shreg;
  logic        sck_drv;

  wire por_done  = (por_cnt == 2'h3);
  wire conv_tick = (tick_cnt == CONV_TICK_LIM);
  wire half_tick = conv_tick & (half_cnt == HALF_LIM);
  wire [15:0] test_lim = ext_osc_active ? EXT_TEST_LIM : TEST_LIM;
  wire at_last   = (bit_cnt == LAST_EDGE);
  wire int_fall  = ~ext_mode & half_tick & sck_drv;
  wire int_rise  = ~ext_mode & half_tick & ~sck_drv;
  wire ext_end   = ext_mode & sck_fall & at_last;
  wire int_end   = int_fall & at_last;
  wire in_shift  = (st == ST_SHIFT);
  wire shift_now = in_shift & ~cs_rise & ~at_last
                 & (ext_mode ? sck_fall : int_fall);
  wire load_res  = (st == ST_CONVERT) & conv_done;
  wire wait_exp  = (st == ST_WAIT) & ~cs_s & (wait_cnt == test_lim);
  wire ext_begin = (st == ST_SLEEP) & ~cs_s & ext_mode & sck_rise;
  wire enter_conv = (next_st == ST_CONVERT) & (st != ST_CONVERT);
  // ext_mode only settles at the same edge, so read the pin level instead
  wire pick_int   = por_done & cs_fall & sck_s;

  // next state of the readout sequencer
  always_comb begin
    next_st = st;
    case (st)
      ST_CONVERT: begin
        if (conv_done) next_st = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (ext_begin) next_st = ST_SHIFT;
        else if (!cs_s && !ext_mode && por_done) next_st = ST_WAIT;
      end
      ST_WAIT: begin
        if (cs_s) next_st = ST_SLEEP;
        else if (wait_exp) next_st = ST_SHIFT;
      end
      ST_SHIFT: begin
        if (cs_rise) next_st = ST_CONVERT;
        else if (ext_end) next_st = ST_CONVERT;
        else if (int_end) next_st = ST_CONVERT;
      end
      default: next_st = ST_CONVERT;
    endcase
  end

  // state register and start pulse for the converter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st         <= ST_CONVERT;
      conv_start <= 1'b0;
    end else begin
      st         <= next_st;
      conv_start <= enter_conv | (por_cnt == 2'h0);
    end
  end

  // power-on: wait for the synchronisers to fill, then take the strap
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt  <= 2'h0;
      ext_mode <= 1'b0;
    end else begin
      if (!por_done) por_cnt <= por_cnt + 2'h1;
      if (por_cnt == POR_CAPTURE) ext_mode <= ~sck_s;
      else if (por_done && cs_fall) ext_mode <= ~sck_s;
    end
  end

  // conversion clock ticks and the serial clock half periods
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 4'h0;
      half_cnt <= 2'h0;
    end else begin
      tick_cnt <= conv_tick ? 4'h0 : tick_cnt + 4'h1;
      if (!in_shift) half_cnt <= 2'h0;
      else if (conv_tick) half_cnt <= half_cnt + 2'h1;
    end
  end

  // status test timer runs only while waiting with select low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= 16'h0;
    end else if (st == ST_WAIT && !cs_s && !wait_exp) begin
      wait_cnt <= wait_cnt + 16'h1;
    end else begin
      wait_cnt <= 16'h0;
    end
  end

  // rising-edge count; the first edge is counted as the frame starts
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= 6'h0;
    end else if (ext_begin || wait_exp) begin
      bit_cnt <= 6'h1;
    end else if (in_shift && (ext_mode ? sck_rise : int_rise)) begin
      bit_cnt <= bit_cnt + 6'h1;
    end
  end

  // static shift register: leading zero is the pending flag bit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shreg <= 32'h0;
    end else if (load_res) begin
      shreg <= {1'b0, conv_result};
    end else if (shift_now) begin
      shreg <= {shreg[30:0], 1'b0};
    end
  end

  // internal serial clock: low at select fall, high at the delay end and held high after the last rising edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sck_drv <= 1'b1;
    end else if (pick_int) begin
      sck_drv <= 1'b0;
    end else if (wait_exp) begin
      sck_drv <= 1'b1;
    end else if (in_shift && !ext_mode && half_tick && !at_last) begin
      sck_drv <= ~sck_drv;
    end else if (in_shift && !ext_mode && half_tick) begin
      sck_drv <= 1'b1;
    end
  end

  // pull-up drops whenever the pin is seen low and only returns with
  // select high, so a released low pin stays low into the next select
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sck_pullup_en <= 1'b1;
    end else if (!sck_s) begin
      sck_pullup_en <= 1'b0;
    end else if (cs_s) begin
      sck_pullup_en <= 1'b1;
    end
  end

  // data pin: pending flag outside the frame, shift register inside
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sdo_out <= 1'b1;
    end else begin
      sdo_out <= (next_st == ST_CONVERT) ? 1'b1 :
                 (next_st == ST_SHIFT) ? shreg[31] : 1'b0;
    end
  end

  assign sdo_oe  = ~cs_s;
  assign sck_oe  = ~ext_mode & ~cs_s & por_done;
  assign sck_out = sck_drv;

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sdo_release_a: assert property (cs_s |-> !sdo_oe)
    else $error("data pin driven while select high");
  flag_conv_a: assert property (
    (st == ST_CONVERT) [*2] |-> sdo_out)
    else $error("pending flag not high while converting");
  auto_sleep_a: assert property (load_res |=> st == ST_SLEEP)
    else $error("no sleep after conversion end");
  hold_sleep_a: assert property (
    (st == ST_SLEEP && cs_s) |=> st == ST_SLEEP)
    else $error("left sleep with select high");
  ext_restart_a: assert property (
    (in_shift && ext_end && !cs_rise) |=> (st == ST_CONVERT && conv_start)
      ##1 sdo_out)
    else $error("no restart at last falling edge");
  abort_conv_a: assert property (
    (in_shift && cs_rise) |=> (st == ST_CONVERT && conv_start))
    else $error("abort did not restart conversion");
  result_load_a: assert property (
    load_res |=> shreg == {1'b0, $past(conv_result)})
    else $error("result not loaded at flag fall");
  mode_pick_a: assert property (
    (por_done && cs_fall) |=> ext_mode == !$past(sck_s))
    else $error("mode not chosen from clock level");
  int_clk_low_a: assert property (
    pick_int |=> (sck_oe && !sck_out))
    else $error("internal clock not driven low");
  test_delay_a: assert property (
    wait_exp |=> (st == ST_SHIFT && sck_out && bit_cnt == 6'h1))
    else $error("output did not begin after delay");
  pullup_off_a: assert property (!sck_s |=> !sck_pullup_en)
    else $error("pull-up on while clock low");
  int_end_a: assert property (
    (in_shift && int_end && !cs_rise) |=> (st == ST_CONVERT && sck_out))
    else $error("internal frame end wrong");

  ext_frame_c: cover property (in_shift && ext_end);
  int_frame_c: cover property (in_shift && int_end);
  abort_c: cover property (in_shift && cs_rise);
  wait_cancel_c: cover property (st == ST_WAIT && cs_s);

endmodule : adc_serial_readout
`default_nettype wire

// ===== rtl/sync2.sv
`default_nettype none
// ============================================================
// two-flop level synchroniser
// ============================================================
module sync2 #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic meta;

  // meta is read only by q
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : sync2
`default_nettype wire
